//--- lcd_pkg.sv
/*
  Constants, state types and register layouts for the segment LCD controller.
  Assumes the CPU core supplies accumulator writes and instruction strobes on MCLK.
*/
// How it works
// - load timer, pick source, then run
// - source one: tick clock over (n+1), halved
// - source zero: timer3 bit4 over (n+1), halved
// - one frame every duty-count LCD clocks
// - RAM one lights pixel automatically
// - RAM file, nibble map to segment, common
// - lit pixel sees full top level
// - reset or back-up: all segment and common drives top
// - supply bit0 zero enables bias divider
// - display off forces divider off
// - size bit picks doubled or single string
// - supply bit3: segment 0 or top input
// - supply bits 2,1: segment 1, 2 pins
// - duty and bias from mode bits 1:0
// - 01 half, 10 third, 11 quarter duty
// - mode register written and read back
// - supply register write only
// - port2 register picks port or segment
// - zero selects segment, one port
package lcd_pkg;

  // =====================================================================
  // register fields
  localparam int          MODE_DUTY_LSB   = 0;
  localparam int          MODE_ON_BIT     = 2;
  localparam int          MODE_SIZE_BIT   = 3;
  localparam int          SUP_DIVDIS_BIT  = 0;
  localparam int          SUP_SEG2_BIT    = 1;
  localparam int          SUP_SEG1_BIT    = 2;
  localparam int          SUP_SEG0_BIT    = 3;
  localparam int          CTL_SRC_BIT     = 2;
  localparam int          CTL_RUN_BIT     = 3;

  // =====================================================================
  // reset values
  localparam logic [3:0]  MODE_RESET      = 4'h0;
  localparam logic [3:0]  SUPPLY_RESET    = 4'h0;
  localparam logic [3:0]  PORT2_RESET     = 4'hF;
  localparam logic [3:0]  TIMER_RESET     = 4'h0;

  // =====================================================================
  // duty codes
  localparam logic [1:0]  DUTY_NONE       = 2'h0;
  localparam logic [1:0]  DUTY_HALF       = 2'h1;
  localparam logic [1:0]  DUTY_THIRD      = 2'h2;
  localparam logic [1:0]  DUTY_QUARTER    = 2'h3;

  // =====================================================================
  // sizes
  localparam int          NUM_SEG         = 32;
  localparam int          NUM_COM         = 4;
  localparam int          RAM_FILES       = 4;
  localparam int          RAM_NIB_BASE    = 8;

  // drive level codes: 3 top, 2 middle, 1 low, 0 ground
  localparam logic [1:0]  LVL_GND         = 2'h0;
  localparam logic [1:0]  LVL_LOW         = 2'h1;
  localparam logic [1:0]  LVL_MID         = 2'h2;
  localparam logic [1:0]  LVL_TOP         = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01
  } div_state_t;

endpackage : lcd_pkg

//--- lcd_frame_divider.sv
/*
  Frame divider timer: reloadable 4-bit down counter plus divide-by-two.
  Assumes count source pulses are single-cycle strobes on MCLK.
*/
`timescale 1ns/1ps
module lcd_frame_divider (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [3:0] load_value,
  input  wire logic       run,
  input  wire logic       src_pulse,
  output logic            lcd_clk,
  output logic            lcd_tick
);

  typedef struct packed {
    lcd_pkg::div_state_t state;
    logic [3:0]          reload;
    logic [3:0]          count;
    logic                half;
    logic                tick;
  } div_reg_t;

  div_reg_t cur;
  div_reg_t next_cur;

  // =====================================================================
  // counter
  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (load) begin
      next_cur.reload = load_value;
      next_cur.count  = load_value;
    end
    unique case (cur.state)
      lcd_pkg::ST_IDLE: begin
        if (run) begin
          next_cur.state = lcd_pkg::ST_RUN;
        end
      end
      lcd_pkg::ST_RUN: begin
        if (!run) begin
          next_cur.state = lcd_pkg::ST_IDLE;
        end else if (src_pulse && !load) begin
          if (cur.count == 4'h0) begin
            next_cur.count = cur.reload;
            next_cur.half  = ~cur.half;
            next_cur.tick  = cur.half;
          end else begin
            next_cur.count = cur.count - 4'h1;
          end
        end
      end
      default: begin
        next_cur.state = lcd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '{lcd_pkg::ST_IDLE, lcd_pkg::TIMER_RESET, lcd_pkg::TIMER_RESET, 1'b0, 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign lcd_clk  = cur.half;
  assign lcd_tick = cur.tick;

endmodule : lcd_frame_divider

//--- lcd_controller.sv
/*
  Segment LCD controller top: control registers, display RAM, scan and drive.
  Assumes the CPU issues one-cycle instruction strobes with the accumulator
  on ACC; drive levels are coded 2-bit per pin for the analog output stage.
*/
`timescale 1ns/1ps
module lcd_controller (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        RAM_BACKUP,
  input  wire logic [3:0]  ACC,
  input  wire logic        WRITE_MODE_REG_INSTR,
  input  wire logic        READ_MODE_REG_INSTR,
  input  wire logic        WRITE_SUPPLY_REG_INSTR,
  input  wire logic        WRITE_PORT2_PIN_REG_INSTR,
  input  wire logic        WRITE_TIMER_INSTR,
  input  wire logic        WRITE_CONTROL_INSTR,
  input  wire logic        SYSTEM_TICK_CLOCK,
  input  wire logic        TIMER3_BIT4_TAP,
  input  wire logic        RAM_WE,
  input  wire logic [1:0]  RAM_FILE,
  input  wire logic [3:0]  RAM_NIBBLE,
  input  wire logic [3:0]  RAM_WDATA,
  output logic      [3:0]  MODE_RDATA,
  output logic             MODE_RVALID,
  output logic      [63:0] SEG_LEVEL,
  output logic      [7:0]  COM_LEVEL,
  output logic             DIVIDER_ENABLE,
  output logic             DIVIDER_SINGLE,
  output logic             BIAS_HALF,
  output logic             SEG0_IS_SEGMENT,
  output logic             SEG1_IS_SEGMENT,
  output logic             SEG2_IS_SEGMENT,
  output logic      [3:0]  PORT2_IS_PORT,
  output logic             LCD_CLK
);

  localparam int NSEG = lcd_pkg::NUM_SEG;
  localparam int NCOM = lcd_pkg::NUM_COM;

  typedef struct packed {
    logic [3:0]          mode;
    logic [3:0]          supply;
    logic [3:0]          port2;
    logic [3:0]          control;
    logic [3:0]          mode_rdata;
    logic                mode_rvalid;
    logic [1:0]          tap_sync;
    logic                tap_prev;
    logic                tap_pulse;
    logic [1:0]          phase;
    logic                invert;
    logic [2*NSEG-1:0]   seg_level;
    logic [2*NCOM-1:0]   com_level;
    logic                div_enable;
    logic                div_single;
    logic                bias_half;
    logic [2:0]          pin_seg;
    logic [3:0]          port2_out;
  } top_reg_t;

  top_reg_t cur;
  top_reg_t next_cur;

  // display RAM: [file][nibble-8], one bit per common
  logic [3:0] disp_ram [0:NSEG-1];

  logic       div_clk;
  logic       div_tick;
  logic       tap_raw;

  // 2-flop synchroniser on the timer3 tap; first flop read only by second
  logic [1:0] tap_ff;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      tap_ff <= 2'h0;
    end else begin
      tap_ff <= {tap_ff[0], TIMER3_BIT4_TAP};
    end
  end
  assign tap_raw = tap_ff[1];

  // =====================================================================
  // frame divider
  // tick or tap source
  lcd_frame_divider u_div (
    .clk        (MCLK),
    .rst        (RST),
    .load       (WRITE_TIMER_INSTR),
    .load_value (ACC),
    .run        (cur.control[lcd_pkg::CTL_RUN_BIT]),
    .src_pulse  (cur.control[lcd_pkg::CTL_SRC_BIT] ? SYSTEM_TICK_CLOCK : cur.tap_pulse),
    .lcd_clk    (div_clk),
    .lcd_tick   (div_tick)
  );

  // =====================================================================
  // display RAM write
  always_ff @(posedge MCLK) begin
    if (RAM_WE && RAM_NIBBLE[3]) begin
      disp_ram[{RAM_FILE, RAM_NIBBLE[2:0]}] <= RAM_WDATA;
    end
  end

  // number of commons in the frame, minus one
  function automatic logic [1:0] last_phase(input logic [1:0] duty);
    unique case (duty)
      lcd_pkg::DUTY_HALF:    last_phase = 2'h1;
      lcd_pkg::DUTY_THIRD:   last_phase = 2'h2;
      default:               last_phase = 2'h3;
    endcase
  endfunction : last_phase

  logic [1:0] duty;
  logic       display_on_bit;
  logic       half_bias;
  assign duty           = cur.mode[lcd_pkg::MODE_DUTY_LSB +: 2];
  assign display_on_bit = cur.mode[lcd_pkg::MODE_ON_BIT];
  assign half_bias      = (duty == lcd_pkg::DUTY_HALF);

  // =====================================================================
  // next state
  always_comb begin
    logic [1:0] nonsel_com;
    logic [1:0] nonsel_seg;
    logic [1:0] sel_hi;
    logic [1:0] sel_lo;
    logic [1:0] lvl_c;
    logic [1:0] lvl_s;
    nonsel_com = lcd_pkg::LVL_MID;
    nonsel_seg = lcd_pkg::LVL_LOW;
    sel_hi     = lcd_pkg::LVL_TOP;
    sel_lo     = lcd_pkg::LVL_GND;
    lvl_c      = lcd_pkg::LVL_TOP;
    lvl_s      = lcd_pkg::LVL_TOP;
    next_cur   = cur;
    next_cur.mode_rvalid = 1'b0;

    if (WRITE_MODE_REG_INSTR) begin
      next_cur.mode = ACC;
    end
    if (READ_MODE_REG_INSTR) begin
      next_cur.mode_rdata  = cur.mode;
      next_cur.mode_rvalid = 1'b1;
    end
    if (WRITE_SUPPLY_REG_INSTR) begin
      next_cur.supply = ACC;
    end
    if (WRITE_PORT2_PIN_REG_INSTR) begin
      next_cur.port2 = ACC;
    end
    if (WRITE_CONTROL_INSTR) begin
      next_cur.control = ACC;
    end

    next_cur.tap_sync  = {cur.tap_sync[0], tap_raw};
    next_cur.tap_prev  = cur.tap_sync[1];
    next_cur.tap_pulse = cur.tap_sync[1] & ~cur.tap_prev;

    if (div_tick) begin
      if (cur.phase >= last_phase(duty)) begin
        next_cur.phase  = 2'h0;
        next_cur.invert = ~cur.invert;
      end else begin
        next_cur.phase = cur.phase + 2'h1;
      end
    end

    if (half_bias) begin
      nonsel_com = lcd_pkg::LVL_MID;
      nonsel_seg = lcd_pkg::LVL_MID;
    end
    if (cur.invert) begin
      sel_hi = lcd_pkg::LVL_GND;
      sel_lo = lcd_pkg::LVL_TOP;
      nonsel_com = half_bias ? lcd_pkg::LVL_MID : lcd_pkg::LVL_LOW;
      nonsel_seg = half_bias ? lcd_pkg::LVL_MID : lcd_pkg::LVL_MID;
    end

    for (int c = 0; c < NCOM; c++) begin
      lvl_c = lcd_pkg::LVL_TOP;
      if (display_on_bit && duty != lcd_pkg::DUTY_NONE) begin
        lvl_c = (2'(c) == cur.phase) ? sel_hi : nonsel_com;
      end
      next_cur.com_level[2*c +: 2] = lvl_c;
    end
    for (int s = 0; s < NSEG; s++) begin
      lvl_s = lcd_pkg::LVL_TOP;
      if (display_on_bit && duty != lcd_pkg::DUTY_NONE) begin
        lvl_s = disp_ram[s][cur.phase] ? sel_lo : nonsel_seg;
      end
      next_cur.seg_level[2*s +: 2] = lvl_s;
    end

    next_cur.div_enable = ~cur.supply[lcd_pkg::SUP_DIVDIS_BIT] & display_on_bit;
    next_cur.div_single = cur.mode[lcd_pkg::MODE_SIZE_BIT];
    // half bias only with code 01
    next_cur.bias_half  = half_bias;
    // shared pin functions (bit one selects level pin)
    next_cur.pin_seg = ~{cur.supply[lcd_pkg::SUP_SEG2_BIT],
                         cur.supply[lcd_pkg::SUP_SEG1_BIT],
                         cur.supply[lcd_pkg::SUP_SEG0_BIT]};
    next_cur.port2_out = cur.port2;

    // back-up forces every segment and common drive to top
    if (RAM_BACKUP) begin
      next_cur.com_level = {NCOM{lcd_pkg::LVL_TOP}};
      next_cur.seg_level = {NSEG{lcd_pkg::LVL_TOP}};
      next_cur.phase     = 2'h0;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cur            <= '0;
      cur.mode       <= lcd_pkg::MODE_RESET;
      cur.supply     <= lcd_pkg::SUPPLY_RESET;
      cur.port2      <= lcd_pkg::PORT2_RESET;
      cur.port2_out  <= lcd_pkg::PORT2_RESET;
      cur.pin_seg    <= 3'h7;
      cur.seg_level  <= {NSEG{lcd_pkg::LVL_TOP}};
      cur.com_level  <= {NCOM{lcd_pkg::LVL_TOP}};
    end else begin
      cur <= next_cur;
    end
  end

  // LCD_CLK is the divider's own flop; one cycle skew is harmless
  assign LCD_CLK         = div_clk;
  assign MODE_RDATA      = cur.mode_rdata;
  assign MODE_RVALID     = cur.mode_rvalid;
  assign SEG_LEVEL       = cur.seg_level;
  assign COM_LEVEL       = cur.com_level;
  assign DIVIDER_ENABLE  = cur.div_enable;
  assign DIVIDER_SINGLE  = cur.div_single;
  assign BIAS_HALF       = cur.bias_half;
  assign SEG0_IS_SEGMENT = cur.pin_seg[0];
  assign SEG1_IS_SEGMENT = cur.pin_seg[1];
  assign SEG2_IS_SEGMENT = cur.pin_seg[2];
  assign PORT2_IS_PORT   = cur.port2_out;

endmodule : lcd_controller

//--- lcd_controller_asserts.sv
/*
  Port checker for the segment LCD controller.
  Assumes one clock MCLK and synchronous active-high RST.
*/
`timescale 1ns/1ps
module lcd_controller_asserts (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        RAM_BACKUP,
  input wire logic [3:0]  ACC,
  input wire logic        WRITE_MODE_REG_INSTR,
  input wire logic        READ_MODE_REG_INSTR,
  input wire logic        WRITE_SUPPLY_REG_INSTR,
  input wire logic        WRITE_PORT2_PIN_REG_INSTR,
  input wire logic [3:0]  MODE_RDATA,
  input wire logic        MODE_RVALID,
  input wire logic [63:0] SEG_LEVEL,
  input wire logic [7:0]  COM_LEVEL,
  input wire logic        DIVIDER_ENABLE,
  input wire logic        DIVIDER_SINGLE,
  input wire logic        BIAS_HALF,
  input wire logic        SEG0_IS_SEGMENT,
  input wire logic        SEG1_IS_SEGMENT,
  input wire logic        SEG2_IS_SEGMENT,
  input wire logic [3:0]  PORT2_IS_PORT
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // =====================================================================
  // sequences
  sequence s_wr_rd;
    WRITE_MODE_REG_INSTR ##2 READ_MODE_REG_INSTR;
  endsequence
  sequence s_all_top;
    (&SEG_LEVEL) && (&COM_LEVEL);
  endsequence
  // =====================================================================
  // properties
  a_reset_all_top: assert property (disable iff (1'b0) RST |=> s_all_top)
    else $error("drive not top after reset");
  a_backup_all_top: assert property (RAM_BACKUP |=> s_all_top)
    else $error("drive not top in back-up");
  a_mode_read_back: assert property (s_wr_rd |=> MODE_RVALID && MODE_RDATA == $past(ACC, 3))
    else $error("mode read-back wrong");
  a_rvalid_has_read: assert property (MODE_RVALID |-> $past(READ_MODE_REG_INSTR))
    else $error("read valid without read");
  a_divider_off: assert property ((WRITE_SUPPLY_REG_INSTR && ACC[0])
    || (WRITE_MODE_REG_INSTR && !ACC[2]) |-> ##2 !DIVIDER_ENABLE)
    else $error("divider not off");
  a_pin_function: assert property (WRITE_SUPPLY_REG_INSTR |-> ##2
    {SEG0_IS_SEGMENT, SEG1_IS_SEGMENT, SEG2_IS_SEGMENT} == ~$past(ACC[3:1], 2))
    else $error("supply pin function wrong");
  a_port2_function: assert property (WRITE_PORT2_PIN_REG_INSTR |-> ##2
    PORT2_IS_PORT == $past(ACC, 2))
    else $error("port2 pin function wrong");
  a_mode_fields: assert property (WRITE_MODE_REG_INSTR |-> ##2 DIVIDER_SINGLE == $past(ACC[3], 2)
    && BIAS_HALF == ($past(ACC[1:0], 2) == lcd_pkg::DUTY_HALF))
    else $error("mode fields wrong");
endmodule : lcd_controller_asserts

bind lcd_controller lcd_controller_asserts chk (.*);

//--- lcd_panel_model.sv
/*
  Passive LCD glass: records every pixel that sees the full drive swing.
  Assumes 2-bit level codes per pin, 3 top and 0 ground.
*/
`timescale 1ns/1ps
module lcd_panel_model (
  input  wire logic        clk,
  input  wire logic        clear,
  input  wire logic [63:0] seg_level,
  input  wire logic [7:0]  com_level,
  output logic      [127:0] seen
);
  logic [1:0] s_lvl;
  logic [1:0] c_lvl;
  always @(posedge clk) begin
    for (int s = 0; s < 32; s++) begin
      for (int c = 0; c < 4; c++) begin
        s_lvl = seg_level[2*s +: 2];
        c_lvl = com_level[2*c +: 2];
        if (clear) seen[4*s+c] <= 1'b0;
        else if ((s_lvl == 2'h3 && c_lvl == 2'h0) || (s_lvl == 2'h0 && c_lvl == 2'h3))
          seen[4*s+c] <= 1'b1;
      end
    end
  end
endmodule : lcd_panel_model

//--- testbench.sv
/*
  Testbench for the segment LCD controller: registers, RAM map, clocking.
  Assumes inputs change on the falling edge of MCLK.
*/
`timescale 1ns/1ps
module testbench;
  logic        MCLK, RST, RAM_BACKUP, READ_MODE_REG_INSTR, SYSTEM_TICK_CLOCK;
  logic        TIMER3_BIT4_TAP, RAM_WE, MODE_RVALID, DIVIDER_ENABLE, DIVIDER_SINGLE;
  logic        BIAS_HALF, SEG0_IS_SEGMENT, SEG1_IS_SEGMENT, SEG2_IS_SEGMENT, LCD_CLK, clear;
  logic [3:0]  ACC, RAM_NIBBLE, RAM_WDATA, MODE_RDATA, PORT2_IS_PORT;
  logic [1:0]  RAM_FILE;
  logic [4:0]  stb;
  logic [63:0] SEG_LEVEL;
  logic [7:0]  COM_LEVEL;
  logic [127:0] seen, expect_px;
  wire logic   WRITE_MODE_REG_INSTR, WRITE_SUPPLY_REG_INSTR, WRITE_PORT2_PIN_REG_INSTR;
  wire logic   WRITE_TIMER_INSTR, WRITE_CONTROL_INSTR;
  int          error_cnt, samples_checked;

  assign {WRITE_CONTROL_INSTR, WRITE_TIMER_INSTR, WRITE_PORT2_PIN_REG_INSTR,
          WRITE_SUPPLY_REG_INSTR, WRITE_MODE_REG_INSTR} = stb;

  lcd_controller uut (.*);
  lcd_panel_model panel (.clk(MCLK), .clear(clear), .seg_level(SEG_LEVEL),
                         .com_level(COM_LEVEL), .seen(seen));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  // timer3 tap rises every 8 cycles, on falling edges
  initial begin
    TIMER3_BIT4_TAP = 1'b0;
    forever #40 TIMER3_BIT4_TAP = ~TIMER3_BIT4_TAP;
  end
  // =====================================================================
  // tasks
  task final_report;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [127:0] got, input logic [127:0] want);
    samples_checked++;
    if (got !== want) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  // strobe k: 0 mode, 1 supply, 2 port2, 3 timer, 4 control
  task wr(input int k, input logic [3:0] v);
    @(negedge MCLK);
    ACC = v;
    stb = 5'(1 << k);
    @(negedge MCLK);
    stb = 5'h0;
  endtask : wr

  task rd(output logic [3:0] d);
    int i;
    @(negedge MCLK);
    READ_MODE_REG_INSTR = 1'b1;
    @(negedge MCLK);
    READ_MODE_REG_INSTR = 1'b0;
    for (i = 0; i < 4 && MODE_RVALID !== 1'b1; i++) @(negedge MCLK);
    if (i == 4) begin
      error_cnt++;
      final_report();
    end
    d = MODE_RDATA;
  endtask : rd

  // cycles from the call until the next LCD clock rise
  task rise(output int c);
    c = 0;
    while (LCD_CLK !== 1'b0 && c < 400) begin @(negedge MCLK); c++; end
    while (LCD_CLK !== 1'b1 && c < 400) begin @(negedge MCLK); c++; end
    if (c >= 400) begin
      error_cnt++;
      final_report();
    end
  endtask : rise
  // =====================================================================
  // sequence of tests
  initial begin
    int         i, c;
    logic [3:0] v, s, d;
    logic       l;
    int         tf [4];
    int         tn [4];
    logic [3:0] td [4];
    tf = '{0, 1, 3, 2};
    tn = '{8, 10, 15, 7};
    td = '{4'h1, 4'h6, 4'h8, 4'hF};
    {RAM_BACKUP, ACC, stb, READ_MODE_REG_INSTR, SYSTEM_TICK_CLOCK, clear} = '0;
    {RAM_WE, RAM_FILE, RAM_NIBBLE, RAM_WDATA} = '0;
    error_cnt = 0;
    samples_checked = 0;
    RST = 1'b1;
    repeat (8) @(negedge MCLK);
    RST = 1'b0;
    chk({SEG_LEVEL, COM_LEVEL, PORT2_IS_PORT}, {76{1'b1}});
    rd(d);
    chk({d, DIVIDER_ENABLE, SEG0_IS_SEGMENT, SEG1_IS_SEGMENT, SEG2_IS_SEGMENT}, 8'h07);
    for (i = 0; i < 16; i++) begin
      v = i[3:0];
      // set the divider-disable bit only when segment 1 and 2 pins are inputs and v[0] is set
      s = {v[3:1], v[0] & v[2] & v[1]};
      wr(1, s);
      wr(2, v);
      wr(0, v);
      rd(d);
      chk(d, v);
      chk({DIVIDER_ENABLE, SEG0_IS_SEGMENT, SEG1_IS_SEGMENT, SEG2_IS_SEGMENT, PORT2_IS_PORT,
           DIVIDER_SINGLE, BIAS_HALF}, {~s[0] & v[2], ~s[3:1], v, v[3], v[1:0] == 2'h1});
      // timer stopped: phase 0, common 0 selected, the rest non-select
      chk(COM_LEVEL, (v[2] && v[1:0] != 2'h0) ? 8'hAB : 8'hFF);
    end
    // display RAM has no reset; clear it so unlit pixels drive real levels
    for (i = 0; i < 32; i++) begin
      @(negedge MCLK);
      {RAM_WE, RAM_FILE, RAM_NIBBLE, RAM_WDATA} = {1'b1, 2'(i / 8), 4'(8 + i % 8), 4'h0};
    end
    expect_px = '0;
    for (i = 0; i < 4; i++) begin
      @(negedge MCLK);
      {RAM_WE, RAM_FILE, RAM_NIBBLE, RAM_WDATA} = {1'b1, 2'(tf[i]), 4'(tn[i]), td[i]};
      @(negedge MCLK);
      RAM_WE = 1'b0;
      for (c = 0; c < 4 && tn[i] >= 8; c++)
        if (td[i][c]) expect_px[4*(8*tf[i]+tn[i]-8)+c] = 1'b1;
    end
    wr(1, 4'h0);
    wr(0, 4'h7);
    wr(3, 4'h2);
    SYSTEM_TICK_CLOCK = 1'b1;
    wr(4, 4'hC);
    rise(c);
    rise(c);
    chk(c, 6);
    clear = 1'b1;
    @(negedge MCLK);
    clear = 1'b0;
    repeat (300) @(negedge MCLK);
    chk(seen, expect_px);
    RAM_BACKUP = 1'b1;
    repeat (2) @(negedge MCLK);
    chk({SEG_LEVEL, COM_LEVEL}, {72{1'b1}});
    RAM_BACKUP = 1'b0;
    wr(4, 4'h0);
    @(negedge MCLK);
    l = LCD_CLK;
    c = 0;
    repeat (60) begin @(negedge MCLK); if (LCD_CLK !== l) c++; end
    chk(c, 0);
    wr(4, 4'h8);
    rise(c);
    rise(c);
    chk(c, 48);
    final_report();
  end
endmodule : testbench
